// ==== logic/osc_divider_cell.sv ====
`timescale 1ns/100ps
// Summary of operation
// - Oscillator clocks time-out, memory clear and master config clock.
// - The oscillator runs near 8 MHz and always between 4 MHz and 10 MHz.
// - Taps are 4th, 9th, 14th and 19th divider bits, each resynchronized.
// - Besides the primary clock the user picks any two of the four taps.
// - After configuration user logic gets the oscillator only if selected.
// - An unused cell stops the oscillator once configuration is done.
module osc_divider_cell
  import osc_pkg::*;
#(
  parameter int unsigned POR_OSC_CYCLES = POR_OSC_CYCLES_DEF
) (
  clk,
  arst_n,
  master_mode,
  mem_clear_req,
  config_done,
  cell_used,
  osc_out_en,
  tap_sel_a,
  tap_sel_b,
  config_clock_out,
  mem_clear_clk,
  por_done,
  user_osc_out,
  tap_a_out,
  tap_b_out,
  osc_running
);
  localparam int unsigned POR_W = $clog2(POR_OSC_CYCLES + 1);
  localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_OSC_CYCLES - 1);
  localparam logic [POR_W-1:0] POR_ZERO = '0;
  localparam logic [POR_W-1:0] POR_ONE = POR_W'(1);

  input wire logic clk;
  input wire logic arst_n;
  input wire logic master_mode;
  input wire logic mem_clear_req;
  input wire logic config_done;
  input wire logic cell_used;
  input wire logic osc_out_en;
  input wire logic [TAP_SEL_W-1:0] tap_sel_a;
  input wire logic [TAP_SEL_W-1:0] tap_sel_b;
  output logic config_clock_out;
  output logic mem_clear_clk;
  output logic por_done;
  output logic user_osc_out;
  output logic tap_a_out;
  output logic tap_b_out;
  output logic osc_running;

  function automatic logic sel_tap(input logic [NUM_TAPS-1:0] taps,
                                   input logic [TAP_SEL_W-1:0] sel);
    sel_tap = taps[sel];
  endfunction

  // ==========================================================
  // configuration state
  osc_state_t state_reg;
  osc_state_t state_next;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_CONFIG: begin
        if (config_done) begin
          state_next = cell_used ? ST_USER : ST_OFF;
        end
      end
      ST_USER: state_next = ST_USER;
      ST_OFF: state_next = ST_OFF;
      default: state_next = ST_CONFIG;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_CONFIG;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // oscillator and divider
  logic [OSC_CNT_W-1:0] osc_cnt_reg;
  logic [OSC_CNT_W-1:0] osc_cnt_next;
  logic osc_reg;
  logic osc_next;
  logic osc_rise;
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic [POR_W-1:0] por_cnt_reg;
  logic [POR_W-1:0] por_cnt_next;
  logic por_next;

  always_comb begin
    osc_cnt_next = osc_cnt_reg;
    osc_next = osc_reg;
    osc_rise = 1'h0;
    div_next = div_reg;
    por_cnt_next = por_cnt_reg;
    por_next = por_done;
    if (state_next == ST_OFF) begin
      // stopped oscillator saves power; divider freezes with it
      osc_cnt_next = OSC_CNT_ZERO;
      osc_next = 1'h0;
    end else if (osc_cnt_reg == OSC_CNT_LAST) begin
      osc_cnt_next = OSC_CNT_ZERO;
      osc_next = !osc_reg;
      osc_rise = !osc_reg;
    end else begin
      osc_cnt_next = osc_cnt_reg + OSC_CNT_ZERO + 4'h1;
    end
    if (osc_rise) begin
      div_next = div_reg + DIV_ONE;
      if (!por_done) begin
        if (por_cnt_reg == POR_LAST) begin
          por_next = 1'h1;
        end else begin
          por_cnt_next = por_cnt_reg + POR_ONE;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_cnt_reg <= OSC_CNT_ZERO;
      osc_reg <= 1'h0;
      div_reg <= DIV_RESET;
      por_cnt_reg <= POR_ZERO;
      por_done <= 1'h0;
    end else begin
      osc_cnt_reg <= osc_cnt_next;
      osc_reg <= osc_next;
      div_reg <= div_next;
      por_cnt_reg <= por_cnt_next;
      por_done <= por_next;
    end
  end

  // ==========================================================
  // tap resynchronizers
  logic [NUM_TAPS-1:0] taps_raw;
  logic [NUM_TAPS-1:0] tap_sync;

  assign taps_raw = {div_reg[TAP3_BIT], div_reg[TAP2_BIT],
                     div_reg[TAP1_BIT], div_reg[TAP0_BIT]};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TAPS; gi = gi + 1) begin : g_tap
      tap_resync u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .tap_in(taps_raw[gi]),
        .tap_out(tap_sync[gi])
      );
    end
  endgenerate

  // ==========================================================
  // output clocks
  logic cfg_clk_next;
  logic clr_next;
  logic running_next;
  logic user_osc_next;
  logic tap_a_next;
  logic tap_b_next;
  logic in_config;
  logic in_user;

  always_comb begin
    in_config = state_reg == ST_CONFIG;
    in_user = state_reg == ST_USER;
    cfg_clk_next = osc_reg & master_mode & in_config;
    clr_next = osc_reg & mem_clear_req & in_config;
    user_osc_next = osc_reg & osc_out_en & in_user;
    // taps stay low during configuration; user logic is not live yet
    tap_a_next = in_user & sel_tap(tap_sync, tap_sel_a);
    tap_b_next = in_user & sel_tap(tap_sync, tap_sel_b);
    running_next = state_next != ST_OFF;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      config_clock_out <= 1'h0;
      mem_clear_clk <= 1'h0;
      user_osc_out <= 1'h0;
      tap_a_out <= 1'h0;
      tap_b_out <= 1'h0;
      osc_running <= 1'h1;
    end else begin
      config_clock_out <= cfg_clk_next;
      mem_clear_clk <= clr_next;
      user_osc_out <= user_osc_next;
      tap_a_out <= tap_a_next;
      tap_b_out <= tap_b_next;
      osc_running <= running_next;
    end
  end

  // ==========================================================
  // checks
  property p_osc_high_time;
    @(posedge clk) disable iff (!arst_n)
      $rose(osc_reg) && state_reg == ST_USER |->
        osc_reg [*3] ##1 !osc_reg;
  endproperty
  a_osc_high_time: assert property (p_osc_high_time)
    else $error("oscillator high phase not three cycles");

  property p_div_step;
    @(posedge clk) disable iff (!arst_n)
      osc_rise |=> div_reg == $past(div_reg) + DIV_ONE;
  endproperty
  a_div_step: assert property (p_div_step)
    else $error("divider did not step on oscillator rise");

  property p_tap_sync;
    @(posedge clk) disable iff (!arst_n)
      ##2 tap_sync == $past(taps_raw, 2);
  endproperty
  a_tap_sync: assert property (p_tap_sync)
    else $error("tap not delayed by two stages");

  property p_tap_a_sel;
    @(posedge clk) disable iff (!arst_n)
      in_user |=> tap_a_out == $past(tap_sync[tap_sel_a]);
  endproperty
  a_tap_a_sel: assert property (p_tap_a_sel)
    else $error("tap a output wrong");

  property p_tap_b_sel;
    @(posedge clk) disable iff (!arst_n)
      in_user |=> tap_b_out == $past(tap_sync[tap_sel_b]);
  endproperty
  a_tap_b_sel: assert property (p_tap_b_sel)
    else $error("tap b output wrong");

  property p_user_osc;
    @(posedge clk) disable iff (!arst_n)
      user_osc_out |-> $past(in_user && osc_out_en && osc_reg);
  endproperty
  a_user_osc: assert property (p_user_osc)
    else $error("user oscillator without selection");

  property p_osc_stop;
    @(posedge clk) disable iff (!arst_n)
      in_config && config_done && !cell_used |=>
        (!osc_reg && !osc_running) [*4];
  endproperty
  a_osc_stop: assert property (p_osc_stop)
    else $error("oscillator kept running when unused");

  property p_config_clock;
    @(posedge clk) disable iff (!arst_n)
      config_clock_out |-> $past(master_mode && in_config && osc_reg);
  endproperty
  a_config_clock: assert property (p_config_clock)
    else $error("config clock outside master configuration");

  property p_por;
    @(posedge clk) disable iff (!arst_n)
      $rose(por_done) |-> $past(por_cnt_reg) == POR_LAST;
  endproperty
  a_por: assert property (p_por)
    else $error("power-on time-out ended early");
endmodule

// ==== logic/osc_pkg.sv ====
package osc_pkg;
  // ==========================================================
  // clocking and oscillator figures
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned OSC_NOM_HZ = 8_000_000;
  localparam int unsigned OSC_MIN_HZ = 4_000_000;
  localparam int unsigned OSC_MAX_HZ = 10_000_000;
  // half period in clk cycles; 50 MHz / 6 gives 8.33 MHz, inside range
  localparam int unsigned OSC_HALF_CYC = CLK_HZ / (2 * OSC_NOM_HZ);
  localparam int unsigned OSC_CNT_W = 4;
  localparam logic [OSC_CNT_W-1:0] OSC_CNT_LAST =
    OSC_CNT_W'(OSC_HALF_CYC - 1);
  localparam logic [OSC_CNT_W-1:0] OSC_CNT_ZERO = 4'h0;

  // ==========================================================
  // divider and taps (fourth, ninth, fourteenth, nineteenth bits)
  localparam int unsigned DIV_W = 19;
  localparam int unsigned NUM_TAPS = 4;
  localparam int unsigned TAP_SEL_W = 2;
  localparam int unsigned TAP0_BIT = 3;
  localparam int unsigned TAP1_BIT = 8;
  localparam int unsigned TAP2_BIT = 13;
  localparam int unsigned TAP3_BIT = 18;
  localparam logic [DIV_W-1:0] DIV_RESET = 19'h00000;
  localparam logic [DIV_W-1:0] DIV_ONE = 19'h00001;

  // ==========================================================
  // power-on time-out length in oscillator periods
  localparam int unsigned POR_OSC_CYCLES_DEF = 16;

  typedef enum logic [1:0] {
    ST_CONFIG,
    ST_USER,
    ST_OFF
  } osc_state_t;
endpackage

// ==== logic/tap_resync.sv ====
`timescale 1ns/100ps
module tap_resync (
  clk,
  arst_n,
  tap_in,
  tap_out
);
  input wire logic clk;
  input wire logic arst_n;
  input wire logic tap_in;
  output logic tap_out;

  logic meta_reg;
  logic meta_next;
  logic sync_next;

  always_comb begin
    meta_next = tap_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= 1'h0;
      tap_out <= 1'h0;
    end else begin
      meta_reg <= meta_next;
      tap_out <= sync_next;
    end
  end
endmodule

// ==== tb/user_array_model.sv ====
`timescale 1ns/100ps
// ==========================================================
// user logic in the array: counts rising edges of the clocks it gets
module user_array_model (
  clk,
  arst_n,
  user_osc_out,
  tap_a_out,
  tap_b_out,
  osc_rises,
  tap_a_rises,
  tap_b_rises
);
  input wire logic clk;
  input wire logic arst_n;
  input wire logic user_osc_out;
  input wire logic tap_a_out;
  input wire logic tap_b_out;
  output logic [15:0] osc_rises;
  output logic [15:0] tap_a_rises;
  output logic [15:0] tap_b_rises;

  logic [2:0] prev_reg;

  // sampled in the clk domain, as real user flops would see them
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_reg <= 3'h0;
      osc_rises <= 16'h0000;
      tap_a_rises <= 16'h0000;
      tap_b_rises <= 16'h0000;
    end else begin
      prev_reg <= {user_osc_out, tap_a_out, tap_b_out};
      if (user_osc_out && !prev_reg[2]) osc_rises <= osc_rises + 16'h0001;
      if (tap_a_out && !prev_reg[1]) tap_a_rises <= tap_a_rises + 16'h0001;
      if (tap_b_out && !prev_reg[0]) tap_b_rises <= tap_b_rises + 16'h0001;
    end
  end
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/100ps
module tb;
  import osc_pkg::*;
  typedef struct packed {logic master; logic clear; logic [1:0] exp;} row_t;
  logic clk, arst_n, master_mode, mem_clear_req, config_done;
  logic cell_used, osc_out_en;
  logic [TAP_SEL_W-1:0] tap_sel_a, tap_sel_b;
  logic config_clock_out, mem_clear_clk, por_done, user_osc_out;
  logic tap_a_out, tap_b_out, osc_running;
  logic [15:0] osc_rises, tap_a_rises, tap_b_rises, o0, a0, b0;
  logic [2:0] seen;
  int err_count, num_checks, n;
  // divider is still below 1024 steps when tap 2 is picked
  localparam int TAP2_MIN =
    ((32'h1 << TAP2_BIT) - 32'h400) * OSC_HALF_CYC * 32'h2;
  // exp: {config_clock_out toggles, mem_clear_clk toggles}
  row_t rows [4] = '{'{1'h0, 1'h0, 2'h0}, '{1'h1, 1'h0, 2'h2},
                     '{1'h0, 1'h1, 2'h1}, '{1'h1, 1'h1, 2'h3}};

  // ==========================================================
  // design and user logic
  osc_divider_cell #(.POR_OSC_CYCLES(4)) osc_divider_cell_inst (
    .clk(clk), .arst_n(arst_n), .master_mode(master_mode),
    .mem_clear_req(mem_clear_req), .config_done(config_done),
    .cell_used(cell_used), .osc_out_en(osc_out_en),
    .tap_sel_a(tap_sel_a), .tap_sel_b(tap_sel_b),
    .config_clock_out(config_clock_out), .mem_clear_clk(mem_clear_clk),
    .por_done(por_done), .user_osc_out(user_osc_out),
    .tap_a_out(tap_a_out), .tap_b_out(tap_b_out),
    .osc_running(osc_running));
  user_array_model user_array_model_inst (
    .clk(clk), .arst_n(arst_n), .user_osc_out(user_osc_out),
    .tap_a_out(tap_a_out), .tap_b_out(tap_b_out), .osc_rises(osc_rises),
    .tap_a_rises(tap_a_rises), .tap_b_rises(tap_b_rises));

  // ==========================================================
  // helpers
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  // inputs always move 1 ns after the edge, never on it
  task automatic step(input int cyc);
    repeat (cyc) @(posedge clk);
    #1;
  endtask

  task automatic snap;
    o0 = osc_rises;
    a0 = tap_a_rises;
    b0 = tap_b_rises;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // full run is about 49k cycles
  initial begin
    repeat (70000) @(posedge clk);
    err_count++;
    end_sim();
  end

  // ==========================================================
  // tests
  initial begin
    err_count = 0;
    num_checks = 0;
    {arst_n, master_mode, mem_clear_req, config_done} = 4'h0;
    {cell_used, osc_out_en, tap_sel_a, tap_sel_b} = 6'h00;
    step(8);
    arst_n = 1'h1;
    step(1);
    check(16'(por_done), 16'h0000, "time-out ended too early");
    foreach (rows[i]) begin
      master_mode = rows[i].master;
      mem_clear_req = rows[i].clear;
      seen = 3'h0;
      repeat (24) begin
        step(1);
        seen = seen | {user_osc_out | tap_a_out | tap_b_out,
                       config_clock_out, mem_clear_clk};
      end
      check(16'(seen[1:0]), 16'(rows[i].exp), "config clocks");
      check(16'(seen[2]), 16'h0000, "user clock during config");
    end
    check(16'(por_done), 16'h0001, "time-out never ended");
    config_done = 1'h1;
    cell_used = 1'h1;
    osc_out_en = 1'h1;
    tap_sel_b = 2'h1;
    step(8);
    snap();
    // a whole tap 1 period: every count below is exact
    step(3072);
    check(osc_rises - o0, 16'h0200, "oscillator rate");
    check(tap_a_rises - a0, 16'h0020, "tap 0 rate");
    check(tap_b_rises - b0, 16'h0001, "tap 1 rate");
    tap_sel_a = 2'h2;
    tap_sel_b = 2'h3;
    step(2);
    snap();
    for (n = 0; n < 52000 && tap_a_out !== 1'h1; n++) step(1);
    check(16'(tap_a_out), 16'h0001, "tap 2 never rose");
    check(16'(n >= TAP2_MIN), 16'h0001, "tap 2 rose too soon");
    check(tap_b_rises - b0, 16'h0000, "tap 3 rose too soon");
    osc_out_en = 1'h0;
    step(2);
    snap();
    step(24);
    check(osc_rises - o0, 16'h0000, "clock not deselected");
    arst_n = 1'h0;
    config_done = 1'h0;
    cell_used = 1'h0;
    step(2);
    arst_n = 1'h1;
    master_mode = 1'h1;
    step(30);
    check(16'(osc_running), 16'h0001, "stopped during config");
    config_done = 1'h1;
    step(2);
    check(16'(osc_running), 16'h0000, "unused cell still runs");
    osc_out_en = 1'h1;
    seen = 3'h0;
    repeat (24) begin
      step(1);
      seen = seen | {config_clock_out, mem_clear_clk, user_osc_out};
    end
    check(16'(seen), 16'h0000, "clock after stop");
    end_sim();
  end
endmodule
